// ### ers_pkg.sv
package ers_pkg;
    // =========================================================
    // register map (word offsets are byte addresses)
    localparam logic [11:0] ERS_STATUS_OFF = 12'h000;
    localparam logic [11:0] ERS_CTRL_OFF = 12'h004;
    localparam logic [11:0] ERS_IRQ_OFF = 12'h008;
    // =========================================================
    // status bit positions
    localparam int ERS_B_TOG = 7;
    localparam int ERS_B_SETUP = 6;
    localparam int ERS_B_OVW = 5;
    localparam int ERS_B_STS = 4;
    localparam int ERS_B_STALL = 3;
    localparam int ERS_B_NAK = 2;
    localparam int ERS_B_ERR = 1;
    localparam int ERS_B_ACK = 0;
    // control bit positions
    localparam int ERS_C_FEN = 1;
    localparam int ERS_C_HALT = 3;
    localparam logic [7:0] ERS_STATUS_RST = 8'h00;
    localparam logic [7:0] ERS_SW_RW_MASK = 8'h41;
    // =========================================================
    // handshake codes returned toward the link
    typedef enum logic [1:0] {
        ERS_HS_NONE = 2'b00,
        ERS_HS_ACK = 2'b01,
        ERS_HS_NAK = 2'b11,
        ERS_HS_STALL = 2'b10
    } ers_hs_t;
endpackage

// ### ers_decide.sv
`timescale 1ns/1ps
`default_nettype none
// pure handshake decision for one out transaction, registered
module ers_decide
    import ers_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic halt,
    input wire logic fen,
    input wire logic rx_err,
    input wire logic pid_match,
    output ers_hs_t hs_reg
);
    ers_hs_t hs_next;
    always_comb begin
        if (!go || rx_err) begin
            hs_next = ERS_HS_NONE;
        end else if (halt) begin
            hs_next = ERS_HS_STALL;
        end else if (!fen) begin
            hs_next = ERS_HS_NAK;
        end else if (pid_match) begin
            hs_next = ERS_HS_ACK;
        end else begin
            // pid mismatch: no handshake code and no toggle
            hs_next = ERS_HS_NONE;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_reg <= ERS_HS_NONE;
        end else begin
            hs_reg <= hs_next;
        end
    end
endmodule
`default_nettype wire

// ### ers_ep0_rx_status.sv
`timescale 1ns/1ps
`default_nettype none
module ers_ep0_rx_status
    import ers_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic setup_start,
    input wire logic setup_end,
    input wire logic setup_ok,
    input wire logic out_end,
    input wire logic out_err,
    input wire logic out_pid,
    input wire logic status_stage,
    output logic [1:0] handshake,
    output logic handshake_valid,
    output logic rx_irq
);
    // =========================================================
    // link events are single-cycle pulses from the same clock
    logic [7:0] status_reg;
    logic fen_reg;
    logic halt_reg;
    logic irq_reg;
    logic end_d_reg;
    logic err_d_reg;
    logic pid_d_reg;
    ers_hs_t hs;
    logic wr;
    logic rd;
    logic sel_ok;
    logic clr_setup;
    logic clr_ack;
    logic ack_set;
    logic setup_done;
    logic [7:0] sw_clr;

    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && !penable && !pwrite;
    assign sel_ok = paddr == ERS_STATUS_OFF || paddr == ERS_CTRL_OFF || paddr == ERS_IRQ_OFF;
    assign setup_done = setup_end && setup_ok;
    // only the two software bits can be touched; the rest ignore writes
    assign sw_clr = pwdata[7:0] & ERS_SW_RW_MASK;
    assign clr_setup = wr && paddr == ERS_STATUS_OFF && sw_clr[ERS_B_SETUP];
    assign clr_ack = wr && paddr == ERS_STATUS_OFF && sw_clr[ERS_B_ACK];
    assign ack_set = end_d_reg && hs == ERS_HS_ACK;

    ers_decide u_decide (
        .pclk(pclk),
        .presetn(presetn),
        .go(out_end),
        .halt(halt_reg),
        .fen(fen_reg),
        .rx_err(out_err),
        .pid_match(out_pid),
        .hs_reg(hs)
    );

    // =========================================================
    // decision registered one cycle; status follows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_d_reg <= 1'b0;
            err_d_reg <= 1'b0;
            pid_d_reg <= 1'b0;
        end else begin
            end_d_reg <= out_end;
            err_d_reg <= out_err;
            pid_d_reg <= out_pid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= ERS_STATUS_RST;
        end else begin
            if (setup_start) begin
                status_reg[ERS_B_OVW] <= 1'b1;
                status_reg[ERS_B_STS] <= 1'b0;
                status_reg[ERS_B_ACK] <= 1'b0;
            end else if (status_stage) begin
                status_reg[ERS_B_STS] <= 1'b1;
            end
            if (setup_end) begin
                status_reg[ERS_B_OVW] <= 1'b0;
            end
            // set wins over software clear
            if (setup_done) begin
                status_reg[ERS_B_SETUP] <= 1'b1;
                status_reg[ERS_B_TOG] <= 1'b1;
            end else if (clr_setup) begin
                status_reg[ERS_B_SETUP] <= 1'b0;
            end
            if (end_d_reg) begin
                status_reg[ERS_B_STALL] <= hs == ERS_HS_STALL;
                status_reg[ERS_B_NAK] <= hs == ERS_HS_NAK;
                status_reg[ERS_B_ERR] <= err_d_reg;
                if (hs == ERS_HS_ACK && pid_d_reg && !setup_done) begin
                    status_reg[ERS_B_TOG] <= ~status_reg[ERS_B_TOG];
                end
            end
            if (ack_set) begin
                status_reg[ERS_B_ACK] <= 1'b1;
            end else if (clr_ack && !setup_start) begin
                status_reg[ERS_B_ACK] <= 1'b0;
            end
        end
    end

    // =========================================================
    // control register: accept enable and halt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fen_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            if (ack_set || setup_done) begin
                fen_reg <= 1'b0;
            end else if (wr && paddr == ERS_CTRL_OFF) begin
                fen_reg <= pwdata[ERS_C_FEN];
            end
            if (setup_done) begin
                halt_reg <= 1'b0;
            end else if (wr && paddr == ERS_CTRL_OFF) begin
                halt_reg <= pwdata[ERS_C_HALT];
            end
        end
    end

    // receive interrupt bit follows ack; a one written to the irq word clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else if (ack_set) begin
            irq_reg <= 1'b1;
        end else if (clr_ack || (wr && paddr == ERS_IRQ_OFF && pwdata[0])) begin
            irq_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handshake <= ERS_HS_NONE;
            handshake_valid <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            handshake <= hs;
            handshake_valid <= end_d_reg && hs != ERS_HS_NONE;
            rx_irq <= irq_reg;
        end
    end

    // =========================================================
    // apb slave: zero wait states, read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !sel_ok;
            if (rd) begin
                case (paddr)
                    ERS_STATUS_OFF: prdata <= {24'h000000, status_reg};
                    ERS_CTRL_OFF: prdata <= {28'h0000000, halt_reg, 1'b0, fen_reg, 1'b0};
                    ERS_IRQ_OFF: prdata <= {31'h00000000, irq_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =========================================================
    property p_setup_flags;
        @(posedge pclk) disable iff (!presetn)
        setup_done |=> status_reg[ERS_B_SETUP] && status_reg[ERS_B_TOG];
    endproperty
    a_setup_flags: assert property (p_setup_flags) else $error("setup flags");
    property p_tog;
        @(posedge pclk) disable iff (!presetn)
        ack_set && pid_d_reg && !setup_done |=> status_reg[ERS_B_TOG] != $past(status_reg[ERS_B_TOG]);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle not inverted");
    property p_clr;
        @(posedge pclk) disable iff (!presetn) clr_setup && !setup_done |=> !status_reg[ERS_B_SETUP];
    endproperty
    a_clr: assert property (p_clr) else $error("setup not cleared");
    property p_ovw;
        @(posedge pclk) disable iff (!presetn) setup_start && !setup_end |=> status_reg[ERS_B_OVW];
    endproperty
    a_ovw: assert property (p_ovw) else $error("overwrite flag");
    property p_sts;
        @(posedge pclk) disable iff (!presetn) setup_start |=> !status_reg[ERS_B_STS];
    endproperty
    a_sts: assert property (p_sts) else $error("status phase");
    property p_stall;
        @(posedge pclk) disable iff (!presetn) out_end && !out_err && halt_reg ##1 1 |=> status_reg[ERS_B_STALL];
    endproperty
    a_stall: assert property (p_stall) else $error("stall bit");
    property p_nak;
        @(posedge pclk) disable iff (!presetn)
        out_end && !out_err && !halt_reg && !fen_reg ##1 1 |=> status_reg[ERS_B_NAK] && !status_reg[ERS_B_STALL];
    endproperty
    a_nak: assert property (p_nak) else $error("nak bit");
    property p_ack_irq;
        @(posedge pclk) disable iff (!presetn) ack_set |=> status_reg[ERS_B_ACK] && irq_reg && !fen_reg ##1 rx_irq;
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("ack effects");
    property p_ack_clr;
        @(posedge pclk) disable iff (!presetn) setup_start && !ack_set |=> !status_reg[ERS_B_ACK];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack not cleared");

    // =========================================================
    // end-of-transaction status, handshake output and setup acceptance
    property p_err;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && err_d_reg |=>
            status_reg[ERS_B_ERR] && !status_reg[ERS_B_STALL] && !status_reg[ERS_B_NAK];
    endproperty
    a_err: assert property (p_err) else $error("error bit");

    property p_err_clr;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && !err_d_reg |=> !status_reg[ERS_B_ERR];
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error bit kept");

    property p_hs_none;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && err_d_reg |=> !handshake_valid;
    endproperty
    a_hs_none: assert property (p_hs_none) else $error("handshake on error");

    property p_hs_stall;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && hs == ERS_HS_STALL |=> handshake_valid && handshake == ERS_HS_STALL;
    endproperty
    a_hs_stall: assert property (p_hs_stall) else $error("stall handshake");

    property p_halt_first;
        @(posedge pclk) disable iff (!presetn)
        out_end && !out_err && halt_reg && !fen_reg ##1 1'b1 |=>
            status_reg[ERS_B_STALL] && !status_reg[ERS_B_NAK];
    endproperty
    a_halt_first: assert property (p_halt_first) else $error("halt not first");

    property p_setup_accept;
        @(posedge pclk) disable iff (!presetn)
        setup_end && setup_ok |=> status_reg[ERS_B_SETUP] && !fen_reg && !halt_reg;
    endproperty
    a_setup_accept: assert property (p_setup_accept) else $error("setup refused");

    // a software write with no link event must leave read-only bits alone
    property p_ro;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == ERS_STATUS_OFF && !setup_start && !setup_end && !status_stage
            && !end_d_reg |=> $stable(status_reg[ERS_B_TOG])
            && $stable(status_reg[ERS_B_OVW:ERS_B_ERR]);
    endproperty
    a_ro: assert property (p_ro) else $error("read-only bit written");

    property p_irq_clr;
        @(posedge pclk) disable iff (!presetn)
        clr_ack && !ack_set |=> !irq_reg;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");

    property p_ack_hold;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && hs != ERS_HS_ACK && !status_reg[ERS_B_ACK] |=> !status_reg[ERS_B_ACK];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack without ack");

    property p_tog_hold;
        @(posedge pclk) disable iff (!presetn)
        end_d_reg && hs != ERS_HS_ACK && !setup_done |=> $stable(status_reg[ERS_B_TOG]);
    endproperty
    a_tog_hold: assert property (p_tog_hold) else $error("toggle moved");

    property p_sts_set;
        @(posedge pclk) disable iff (!presetn)
        status_stage && !setup_start |=> status_reg[ERS_B_STS];
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("status phase not set");

    property p_ovw_clr;
        @(posedge pclk) disable iff (!presetn)
        setup_end |=> !status_reg[ERS_B_OVW];
    endproperty
    a_ovw_clr: assert property (p_ovw_clr) else $error("overwrite kept");

    property p_irq_out;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> rx_irq == $past(irq_reg);
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output");

    c_setup: cover property (@(posedge pclk) setup_done);
    c_ack: cover property (@(posedge pclk) ack_set);
    c_stall: cover property (@(posedge pclk) end_d_reg && hs == ERS_HS_STALL);
endmodule
`default_nettype wire

// ### ers_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side of the link: one event per request
module ers_host_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic bad,
    input wire logic pid,
    output logic setup_start,
    output logic setup_end,
    output logic setup_ok,
    output logic out_end,
    output logic out_err,
    output logic out_pid,
    output logic status_stage
);
    initial begin
        {setup_start, setup_end, setup_ok, out_end, out_err, out_pid, status_stage} = 7'h00;
    end
    // qualifiers flip outside their strobe so a stale level never passes
    always @(posedge pclk) begin
        setup_start <= go && kind == 2'h0;
        setup_end <= go && kind == 2'h3;
        out_end <= go && kind == 2'h1;
        status_stage <= go && kind == 2'h2;
        setup_ok <= (go && kind == 2'h3) ? !bad : !setup_ok;
        out_err <= (go && kind == 2'h1) ? bad : !out_err;
        out_pid <= (go && kind == 2'h1) ? pid : !out_pid;
    end
endmodule
`default_nettype wire

// ### ers_ep0_rx_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module ers_ep0_rx_status_bench;
    import ers_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, handshake_valid, rx_irq, go = 1'b0, bad = 1'b0, pid = 1'b0;
    logic [1:0] handshake, kind = 2'h0;
    logic setup_start, setup_end, setup_ok, out_end, out_err, out_pid, status_stage;
    logic [32:0] exp_rd[$], exp_mk[$], exp_hs[$], want;
    logic exp_iq[$], iq_seen = 1'b0;
    int failures = 0, num_checks = 0, cycles = 0, seed = 26902;
    localparam logic [2:0] hs_ack = {1'b1, ERS_HS_ACK};
    localparam logic [2:0] hs_nak = {1'b1, ERS_HS_NAK};
    localparam logic [2:0] hs_stall = {1'b1, ERS_HS_STALL};
    always #2.5 pclk = ~pclk;
    ers_ep0_rx_status u_ers_ep0_rx_status (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .setup_start(setup_start),
        .setup_end(setup_end), .setup_ok(setup_ok), .out_end(out_end), .out_err(out_err),
        .out_pid(out_pid), .status_stage(status_stage), .handshake(handshake),
        .handshake_valid(handshake_valid), .rx_irq(rx_irq));
    ers_host_model u_ers_host_model (.pclk(pclk), .go(go), .kind(kind), .bad(bad), .pid(pid),
        .setup_start(setup_start), .setup_end(setup_end), .setup_ok(setup_ok),
        .out_end(out_end), .out_err(out_err), .out_pid(out_pid), .status_stage(status_stage));
    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] want);
        num_checks++;
        if (got !== want) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // ==========================================
    // monitor: every answer takes the oldest note
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end else begin
            if (pready === 1'b1)
                check({pslverr, prdata} & exp_mk.pop_front(), exp_rd.pop_front());
            if (handshake_valid === 1'b1) begin
                want = exp_hs.size() > 0 ? exp_hs.pop_front() : 33'h1_0000_0000;
                check({31'h0, handshake}, want);
            end
            if (presetn === 1'b1 && rx_irq !== iq_seen) begin
                iq_seen = rx_irq;
                want = exp_iq.size() > 0 ? {32'h0, exp_iq.pop_front()} : 33'h1_0000_0000;
                check({32'h0, rx_irq}, want);
            end
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        exp_rd.push_back(e);
        exp_mk.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        apb(1'b0, a, 32'h0, {25'h0, e}, {25'h1FF_FFFF, m});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask
    // kind: 0 setup start, 3 setup end, 1 out, 2 status stage
    task automatic ev(input logic [1:0] k, input logic b, input logic p, input logic [2:0] h);
        if (h[2]) exp_hs.push_back({31'h0, h[1:0]});
        kind <= k;
        bad <= b;
        pid <= p;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ERS_STATUS_OFF, 8'h00, 8'hFF);
        rd(ERS_CTRL_OFF, 8'h00, 8'hFF);
        rd(ERS_IRQ_OFF, 8'h00, 8'h01);
        apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        ev(2'h1, 1'b0, 1'b1, hs_nak);
        rd(ERS_STATUS_OFF, 8'h04, 8'hFF);
        wr(ERS_CTRL_OFF, 32'h8);
        ev(2'h1, 1'b0, 1'b1, hs_stall);
        rd(ERS_STATUS_OFF, 8'h08, 8'hFF);
        ev(2'h0, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'h28, 8'hFF);
        ev(2'h3, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'hC8, 8'hFF);
        rd(ERS_CTRL_OFF, 8'h00, 8'hFF);
        wr(ERS_STATUS_OFF, $random(seed) | 32'h40);
        rd(ERS_STATUS_OFF, 8'h88, 8'hFF);
        ev(2'h2, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'h98, 8'hFF);
        wr(ERS_CTRL_OFF, 32'h2);
        exp_iq.push_back(1'b1);
        ev(2'h1, 1'b0, 1'b1, hs_ack);
        rd(ERS_STATUS_OFF, 8'h11, 8'hFF);
        rd(ERS_CTRL_OFF, 8'h00, 8'hFF);
        rd(ERS_IRQ_OFF, 8'h01, 8'h01);
        ev(2'h1, 1'b0, 1'b1, hs_nak);
        rd(ERS_STATUS_OFF, 8'h15, 8'hFF);
        wr(ERS_CTRL_OFF, 32'h2);
        ev(2'h1, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'h00, 8'h80);
        ev(2'h1, 1'b1, 1'b1, 3'h0);
        rd(ERS_STATUS_OFF, 8'h12, 8'hFE);
        exp_iq.push_back(1'b0);
        wr(ERS_STATUS_OFF, 32'h1);
        rd(ERS_IRQ_OFF, 8'h00, 8'h01);
        wr(ERS_CTRL_OFF, 32'h2);
        exp_iq.push_back(1'b1);
        ev(2'h1, 1'b0, 1'b1, hs_ack);
        rd(ERS_STATUS_OFF, 8'h81, 8'h81);
        exp_iq.push_back(1'b0);
        wr(ERS_IRQ_OFF, 32'h1);
        rd(ERS_IRQ_OFF, 8'h00, 8'h01);
        ev(2'h0, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'h20, 8'h31);
        wr(ERS_CTRL_OFF, 32'h8);
        ev(2'h3, 1'b1, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'h80, 8'hE0);
        rd(ERS_CTRL_OFF, 8'h08, 8'hFF);
        ev(2'h3, 1'b0, 1'b0, 3'h0);
        rd(ERS_STATUS_OFF, 8'hC0, 8'hE0);
        rd(ERS_CTRL_OFF, 8'h00, 8'hFF);
        check(33'(exp_hs.size() + exp_iq.size()), 33'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
